// *** hdl/ppd_defines.svh ***
`ifndef PPD_DEFINES_SVH
`define PPD_DEFINES_SVH

`define PPD_DIV_RATIO   256
`define PPD_DIV_W       8
`define PPD_DIV_ZERO    8'h00
`define PPD_DIV_HALF    8'h80
`define PPD_DIV_ONE     8'h01
`define PPD_DIV_LAST    8'hff

`endif

// *** hdl/ppd_pkg.sv ***
package ppd_pkg;

  typedef struct packed {
    logic sink;
    logic source;
  } ppd_pump_s;

  typedef enum logic [1:0] {
    PPD_PUMP_IDLE,
    PPD_PUMP_SINK,
    PPD_PUMP_SOURCE
  } ppd_pump_e;

endpackage : ppd_pkg

// *** hdl/ppd_core.sv ***
`timescale 1ns/10ps
`include "ppd_defines.svh"

// How it works
// - Prescaler divides VCO input by 256
// - Detector acts on rising edges only
// - Flags span plus/minus two pi phase
// - Feedback first or faster: pump sinks
// - Reference first or faster: pump sources
// - Pulse spans earlier to later edge
// - Matched clocks leave pump quiet
// - Pump output sink, source or hi-Z
module ppd_core (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       vco_in,
  input  wire logic       ref_osc_input,
  output logic            ref_osc_feedback,
  output logic            divided_vco_signal,
  output logic            pump_sink,
  output logic            pump_source,
  output logic            charge_pump_output,
  output logic            charge_pump_output_oe
);

  // Three-stage input synchronisers; change counts when stages 2 and 3 agree
  logic [2:0] vco_sync_r, vco_sync_nxt;
  logic [2:0] ref_sync_r, ref_sync_nxt;
  logic       vco_lvl_r, vco_lvl_nxt;
  logic       ref_lvl_r, ref_lvl_nxt;
  logic       vco_rise, ref_rise;

  always_comb begin
    vco_sync_nxt = {vco_sync_r[1:0], vco_in};
    ref_sync_nxt = {ref_sync_r[1:0], ref_osc_input};
    vco_lvl_nxt  = vco_lvl_r;
    ref_lvl_nxt  = ref_lvl_r;
    if (vco_sync_r[1] == vco_sync_r[2]) begin
      vco_lvl_nxt = vco_sync_r[2];
    end
    if (ref_sync_r[1] == ref_sync_r[2]) begin
      ref_lvl_nxt = ref_sync_r[2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vco_sync_r <= 3'h0;
      ref_sync_r <= 3'h0;
      vco_lvl_r  <= 1'b0;
      ref_lvl_r  <= 1'b0;
    end else begin
      vco_sync_r <= vco_sync_nxt;
      ref_sync_r <= ref_sync_nxt;
      vco_lvl_r  <= vco_lvl_nxt;
      ref_lvl_r  <= ref_lvl_nxt;
    end
  end

  // Inverted reference echoed back, as the oscillator buffer does
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_osc_feedback <= 1'b1;
    end else begin
      ref_osc_feedback <= ~ref_lvl_r;
    end
  end

  // Prescaler: one feedback rise per 256 VCO rises
  logic [`PPD_DIV_W-1:0] div_cnt_r, div_cnt_nxt;
  logic                  fb_lvl_r, fb_lvl_nxt;
  logic                  fb_rise;

  always_comb begin
    vco_rise    = vco_lvl_nxt & ~vco_lvl_r;
    ref_rise    = ref_lvl_nxt & ~ref_lvl_r;
    div_cnt_nxt = div_cnt_r;
    if (vco_rise) begin
      div_cnt_nxt = div_cnt_r + `PPD_DIV_ONE;
    end
    fb_lvl_nxt = (div_cnt_nxt < `PPD_DIV_HALF);
    fb_rise    = fb_lvl_nxt & ~fb_lvl_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= `PPD_DIV_ZERO;
      fb_lvl_r  <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      fb_lvl_r  <= fb_lvl_nxt;
    end
  end

  // Phase/frequency detector; a flag waits across whole periods so the
  // decision holds over two pi either way before wrapping
  ppd_pkg::ppd_pump_s flags_r, flags_nxt;
  logic               fb_rise_r, ref_rise_r;

  always_comb begin
    flags_nxt = flags_r;
    if (fb_rise) begin
      flags_nxt.sink = 1'b1;
    end
    if (ref_rise) begin
      flags_nxt.source = 1'b1;
    end
    // Coincident edges cancel at once: lock gives no pulse
    if (flags_nxt.sink && flags_nxt.source) begin
      flags_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r    <= '0;
      fb_rise_r  <= 1'b0;
      ref_rise_r <= 1'b0;
    end else begin
      flags_r    <= flags_nxt;
      fb_rise_r  <= fb_rise;
      ref_rise_r <= ref_rise;
    end
  end

  always_comb begin
    divided_vco_signal    = fb_lvl_r;
    pump_sink             = flags_r.sink;
    pump_source           = flags_r.source;
    charge_pump_output    = flags_r.source;
    charge_pump_output_oe = flags_r.sink | flags_r.source;
  end

  // The other flag is looked at as it stood before the edge: a set flag
  // there means the edge ended a pulse instead of starting one
  sequence s_fb_first;
    fb_rise_r && !ref_rise_r && !$past(flags_r.source);
  endsequence

  sequence s_ref_first;
    ref_rise_r && !fb_rise_r && !$past(flags_r.sink);
  endsequence

  a_sink_starts: assert property (@(posedge clk) disable iff (!rst_n)
    s_fb_first |-> pump_sink) else $error("sink not raised after feedback edge");

  a_source_starts: assert property (@(posedge clk) disable iff (!rst_n)
    s_ref_first |-> pump_source) else $error("source not raised after ref edge");

  a_never_both: assert property (@(posedge clk) disable iff (!rst_n)
    !(pump_sink && pump_source)) else $error("sink and source together");

  a_sink_ends: assert property (@(posedge clk) disable iff (!rst_n)
    pump_sink && ref_rise |=> !pump_sink) else $error("sink outlived ref edge");

  a_source_ends: assert property (@(posedge clk) disable iff (!rst_n)
    pump_source && fb_rise |=> !pump_source) else $error("source outlived fb edge");

  a_coincident_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !pump_sink && !pump_source && fb_rise && ref_rise |=> !charge_pump_output_oe)
    else $error("pump pulsed on coincident edges");

  a_hiz_idle: assert property (@(posedge clk) disable iff (!rst_n)
    charge_pump_output_oe == (pump_sink || pump_source)) else $error("enable mismatch");

  a_drive_level: assert property (@(posedge clk) disable iff (!rst_n)
    charge_pump_output_oe |-> charge_pump_output == pump_source)
    else $error("pump level wrong");

  a_div_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    vco_rise && div_cnt_r == `PPD_DIV_LAST |=> div_cnt_r == `PPD_DIV_ZERO && fb_lvl_r)
    else $error("prescaler wrap wrong");

  a_fb_rise_point: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(fb_lvl_r) |-> div_cnt_r == `PPD_DIV_ZERO) else $error("feedback rose off count");

  a_flag_holds: assert property (@(posedge clk) disable iff (!rst_n)
    pump_sink && !ref_rise |=> pump_sink) else $error("sink flag dropped early");

  a_source_holds: assert property (@(posedge clk) disable iff (!rst_n)
    pump_source && !fb_rise |=> pump_source) else $error("source flag dropped early");

  a_fb_level: assert property (@(posedge clk) disable iff (!rst_n)
    fb_lvl_r == (div_cnt_r < `PPD_DIV_HALF)) else $error("feedback level off count");

  a_div_still: assert property (@(posedge clk) disable iff (!rst_n)
    !vco_rise |=> $stable(div_cnt_r)) else $error("prescaler moved without edge");

  a_fb_edge_rising: assert property (@(posedge clk) disable iff (!rst_n)
    fb_rise |-> !fb_lvl_r) else $error("feedback edge from high level");

  a_ref_filtered: assert property (@(posedge clk) disable iff (!rst_n)
    ref_rise |-> ref_sync_r[1] && ref_sync_r[2]) else $error("ref edge not filtered");

  a_sink_drive_low: assert property (@(posedge clk) disable iff (!rst_n)
    pump_sink |-> charge_pump_output_oe && !charge_pump_output)
    else $error("sink not driven low");

  a_sink_cause: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pump_sink) |-> $past(fb_rise)) else $error("sink rose without feedback edge");

  a_source_cause: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pump_source) |-> $past(ref_rise)) else $error("source rose without ref edge");

  // Echo is the inverse of the filtered level one cycle on
  a_ref_echo: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> ref_osc_feedback == !$past(ref_lvl_r)) else $error("ref echo wrong");

endmodule : ppd_core

// *** verification/ppd_vco_model.sv ***
`timescale 1ns/10ps
module ppd_vco_model #(parameter int HALF = 3) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pump,
  input  wire logic oe,
  output logic      vco
);
  int cnt;
  int lvl;
  // Open loop: a fixed rate keeps pulse widths predictable
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      vco <= 1'h0;
      lvl <= 0;
    end else begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) vco <= !vco;
      if (oe) lvl <= pump ? lvl + 1 : lvl - 1;
    end
  end
endmodule : ppd_vco_model

// *** verification/pll_prescaler_phase_detector_tb_top.sv ***
`timescale 1ns/10ps
module pll_prescaler_phase_detector_tb_top;
  localparam int PER = 1536;
  typedef struct {int d1; int d2; bit gl;} ppd_row_s;
  ppd_row_s rows [4] = '{'{10, 10, 0}, '{40, 25, 0}, '{40, 60, 1}, '{5, 90, 0}};
  logic clk   = 0;
  logic rst_n = 0;
  logic rin   = 0;
  logic vco, fb, snk, src, po, oe, ofb;
  int   n_fail, cmp_count, cyc, rs, rr, ws, wr, bad, k0, t0;
  always #10 clk = ~clk;
  ppd_vco_model #(.HALF(3)) u_vco (.clk(clk), .rst_n(rst_n), .pump(po), .oe(oe), .vco(vco));
  ppd_core dut (.clk(clk), .rst_n(rst_n), .vco_in(vco), .ref_osc_input(rin),
    .ref_osc_feedback(ofb), .divided_vco_signal(fb), .pump_sink(snk), .pump_source(src),
    .charge_pump_output(po), .charge_pump_output_oe(oe));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rs <= snk ? rs + 1 : 0;
    rr <= src ? rr + 1 : 0;
    if (!snk && rs > 0) ws <= rs;
    if (!src && rr > 0) wr <= rr;
    if (oe !== (snk | src) || (snk && src) || (oe && po !== src)) bad <= bad + 1;
  end
  task automatic cmp(string nm, int e, int g);
    cmp_count++;
    if (e != g) begin
      n_fail++;
      $display("CHECK FAILED %s exp %0d got %0d", nm, e, g);
    end
  endtask : cmp
  task automatic cmpb(string nm, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask : cmpb
  task automatic wait_fb;
    for (int i = 0; i < 4 * PER && fb !== 1'h0; i++) @(posedge clk);
    for (int i = 0; i < 4 * PER && fb !== 1'h1; i++) @(posedge clk);
  endtask : wait_fb
  task automatic pulse(int n);
    rin <= 1'h1;
    repeat (n) @(posedge clk);
    rin <= 1'h0;
    @(posedge clk);
  endtask : pulse
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  initial begin
    #(20 * 30000);
    n_fail++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge clk);
    cmpb("fb", 1, fb);
    cmpb("oe", 0, oe);
    cmpb("ofb", 1, ofb);
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    $display("reset test done");
    wait_fb;
    t0 = cyc;
    wait_fb;
    cmp("fb period", PER, cyc - t0);
    pulse(8);
    $display("period test done");
    // Each row: sink of d1, then source of d2; a pin-to-pin skew k cancels in the sum
    foreach (rows[j]) begin
      wait_fb;
      if (rows[j].gl) begin
        repeat (rows[j].d1 / 2) @(posedge clk);
        pulse(1);
        repeat (rows[j].d1 - rows[j].d1 / 2 - 2) @(posedge clk);
      end else repeat (rows[j].d1) @(posedge clk);
      pulse(8);
      cmpb("ofb", 0, ofb);
      repeat (PER - rows[j].d1 - rows[j].d2 - 9) @(posedge clk);
      pulse(8);
      repeat (rows[j].d2 + 20) @(posedge clk);
      if (j == 0) k0 = ws - rows[j].d1;
      cmp("sum", rows[j].d1 + rows[j].d2, ws + wr);
      cmp("sink skew", k0, ws - rows[j].d1);
      $display("row %0d done", j);
    end
    wait_fb;
    repeat (3) @(posedge clk);
    cmpb("snk", 1, snk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    cmpb("snk", 0, snk);
    cmpb("fb", 1, fb);
    rst_n <= 1'h1;
    cmp("pump drive", 0, bad);
    $display("mid reset test done");
    final_report;
  end
endmodule : pll_prescaler_phase_detector_tb_top
